//--- haptic_setup_pkg.sv
// Package for the haptic drive setup and control register bank.
// Assumes a single 100 MHz core clock and a classic Wishbone slave bus.
package haptic_setup_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 10000;          // 100 MHz
  localparam int unsigned BOOT_TIME_US    = 1500;           // Boot time, 1.5 ms
  localparam int unsigned BOOT_CYCLES     = (BOOT_TIME_US * 1000000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS       = 8'h00;  // Boot and mode state, read only
  localparam logic [7:0] OFS_ACT_CFG      = 8'h04;  // Kind and feature enables
  localparam logic [7:0] OFS_NOM_LIMIT    = 8'h08;  // Nominal drive limit
  localparam logic [7:0] OFS_PEAK_LIMIT   = 8'h0C;  // Peak drive limit
  localparam logic [7:0] OFS_CUR_LIMIT    = 8'h10;  // Current limit code
  localparam logic [7:0] OFS_IMP_HIGH     = 8'h14;  // Impedance scale high byte
  localparam logic [7:0] OFS_IMP_LOW      = 8'h18;  // Impedance scale low byte
  localparam logic [7:0] OFS_PER_HIGH     = 8'h1C;  // Resonance period high part
  localparam logic [7:0] OFS_PER_LOW      = 8'h20;  // Resonance period low part
  localparam logic [7:0] OFS_PLAY_MODE    = 8'h24;  // Play mode select
  localparam logic [7:0] OFS_STORE_UNLOCK = 8'h28;  // Pattern store unlock
  localparam logic [7:0] OFS_STORE_START  = 8'h2C;  // Start location, read only
  localparam logic [7:0] OFS_STORE_ADDR   = 8'h30;  // Store access pointer
  localparam logic [7:0] OFS_STORE_DATA   = 8'h34;  // Store data port

  // ----------------------------------------------------------------
  // Field positions in the configuration register
  // ----------------------------------------------------------------
  localparam int unsigned BIT_KIND        = 0;  // 0 linear, 1 rotating mass
  localparam int unsigned BIT_FOLLOW_EN   = 1;  // Resonance following enable
  localparam int unsigned BIT_OVERDRV_EN  = 2;  // Overdrive assist enable
  localparam int unsigned BIT_BRAKE_EN    = 3;  // Fast braking enable
  localparam int unsigned BIT_WIDEBAND    = 4;  // Wideband drive request

  // ----------------------------------------------------------------
  // Store geometry and reset values
  // ----------------------------------------------------------------
  localparam int unsigned STORE_DEPTH     = 256;
  localparam logic [7:0]  FIRST_SLOT_LOC  = 8'h00;  // First snippet slot
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [14:0] RST_PERIOD      = 15'h0000;
  localparam logic [15:0] RST_IMPEDANCE   = 16'h0000;

  // Wideband period bounds in 1333.32 ns units: 25 Hz and 1000 Hz
  localparam logic [14:0] WB_PERIOD_MAX   = 15'h7530;
  localparam logic [14:0] WB_PERIOD_MIN   = 15'h02EE;

  // ----------------------------------------------------------------
  // Play modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_INACTIVE = 3'h0,
    MODE_DIRECT   = 3'h1,
    MODE_STREAM   = 3'h2,
    MODE_REG_PLAY = 3'h3,
    MODE_EDGE_PLAY= 3'h4
  } play_mode_type;

  // Boot sequencer states, one hot
  typedef enum logic [2:0] {
    ST_RESET    = 3'b001,
    ST_BOOT     = 3'b010,
    ST_INACTIVE = 3'b100
  } boot_state_type;

  // Drive settings presented to the output stage
  typedef struct packed {
    logic        kindRotating;
    logic        followEn;
    logic        overdriveEn;
    logic        brakeEn;
    logic        wideband;
    logic [7:0]  nominalLimit;
    logic [7:0]  peakLimit;
    logic [4:0]  currentLimitCode;
    logic [15:0] impedanceScale;
    logic [14:0] resonancePeriod;
  } drive_cfg_type;

endpackage

//--- haptic_drive_setup_control.sv
// Haptic drive setup and control register bank with pattern store.
// Assumes a classic Wishbone master on core_clk and an output stage
// that consumes the drive settings bundle.
//
// Function
// - Boot 1.5 ms then enter inactive mode
// - Kind field: 0 linear, 1 rotating mass
// - Nominal RMS limit, 8-bit, 23.4 mV steps
// - Peak limit, 8-bit, 23.4 mV steps
// - Current limit code is 5 bits wide
// - Period 15 bits: high part, 7-bit low
// - Rotating mass: period sets sensing rate
// - Independent enables for three drive features
// - Assist applies overdrive on level changes
// - Braking drives full reverse, phase or voltage
// - Wideband only in three playback modes
// - Wideband accepts 25 Hz to 1000 Hz
// - Direct mode adopts newly written period
// - Store writes refused while locked
// - Readable start location of first slot
// - Store starts empty, rewritable when unlocked and inactive after boot
// - Mode zero means inactive low power
`timescale 1ns/10ps

module haptic_drive_setup_control (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  // Wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  // Drive side
  output haptic_setup_pkg::drive_cfg_type    driveCfg,
  output logic                               bootDone,
  output logic                               lowPower,
  output logic                               assistActive,
  output logic                               brakeReverse,
  output logic                               sensingRateMode,
  output logic                               widebandActive
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        req;        // New request this cycle
  logic        wrReq;      // Write request with low lane
  logic        storeOpen;  // Store writes allowed now
  logic        storeWe;    // Accepted store data write
  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrReq = req && wb_we_i && wb_sel_i[0];

  // ----------------------------------------------------------------
  // Boot sequencer
  // ----------------------------------------------------------------
  haptic_setup_pkg::boot_state_type bootState_r, bootState_nxt;
  logic [17:0] bootCnt_r, bootCnt_nxt;   // Boot time counter

  // Next boot state
  always_comb begin
    bootState_nxt = bootState_r;
    bootCnt_nxt   = bootCnt_r;
    unique case (bootState_r)
      haptic_setup_pkg::ST_RESET: begin
        bootState_nxt = haptic_setup_pkg::ST_BOOT;
        bootCnt_nxt   = 18'h0_0000;
      end
      haptic_setup_pkg::ST_BOOT: begin
        // Count out the full boot time
        if (bootCnt_r == 18'(haptic_setup_pkg::BOOT_CYCLES - 1))
          bootState_nxt = haptic_setup_pkg::ST_INACTIVE;
        else
          bootCnt_nxt = bootCnt_r + 18'h0_0001;
      end
      haptic_setup_pkg::ST_INACTIVE: bootState_nxt = haptic_setup_pkg::ST_INACTIVE;
      default: bootState_nxt = haptic_setup_pkg::ST_RESET;
    endcase
  end

  // Boot state registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bootState_r <= haptic_setup_pkg::ST_RESET;
      bootCnt_r   <= 18'h0_0000;
    end else begin
      bootState_r <= bootState_nxt;
      bootCnt_r   <= bootCnt_nxt;
    end
  end

  logic booted;   // Boot finished
  assign booted = (bootState_r == haptic_setup_pkg::ST_INACTIVE);

  // ----------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------
  logic [4:0]  actCfg_r, actCfg_nxt;          // Kind and enables
  logic [7:0]  nomLimit_r, nomLimit_nxt;      // Nominal limit
  logic [7:0]  peakLimit_r, peakLimit_nxt;    // Peak limit
  logic [4:0]  curLimit_r, curLimit_nxt;      // Current limit code
  logic [7:0]  impHigh_r, impHigh_nxt;        // Staged high byte
  logic [7:0]  impLow_r, impLow_nxt;          // Staged low byte
  logic [1:0]  impSeen_r, impSeen_nxt;        // Bytes written
  logic [15:0] impedance_r, impedance_nxt;    // Committed scale
  logic [7:0]  perHigh_r, perHigh_nxt;        // Staged high part
  logic [6:0]  perLow_r, perLow_nxt;          // Staged low part
  logic [1:0]  perSeen_r, perSeen_nxt;        // Parts written
  logic [14:0] period_r, period_nxt;          // Committed period
  logic [2:0]  playMode_r, playMode_nxt;      // Play mode select
  logic        unlock_r, unlock_nxt;          // Store unlock
  logic [7:0]  storeAddr_r, storeAddr_nxt;    // Store pointer

  // Decode helper for write hits
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction

  // Next settings values
  always_comb begin
    actCfg_nxt    = actCfg_r;
    nomLimit_nxt  = nomLimit_r;
    peakLimit_nxt = peakLimit_r;
    curLimit_nxt  = curLimit_r;
    impHigh_nxt   = impHigh_r;
    impLow_nxt    = impLow_r;
    impSeen_nxt   = impSeen_r;
    impedance_nxt = impedance_r;
    perHigh_nxt   = perHigh_r;
    perLow_nxt    = perLow_r;
    perSeen_nxt   = perSeen_r;
    period_nxt    = period_r;
    playMode_nxt  = playMode_r;
    unlock_nxt    = unlock_r;
    storeAddr_nxt = storeAddr_r;
    if (wrReq) begin
      // Kind and three independent enables
      if (hit(wb_adr_i, haptic_setup_pkg::OFS_ACT_CFG))    actCfg_nxt = wb_dat_i[4:0];
      // Voltage limit codes
      if (hit(wb_adr_i, haptic_setup_pkg::OFS_NOM_LIMIT))  nomLimit_nxt = wb_dat_i[7:0];
      if (hit(wb_adr_i, haptic_setup_pkg::OFS_PEAK_LIMIT)) peakLimit_nxt = wb_dat_i[7:0];
      // Five-bit current code
      if (hit(wb_adr_i, haptic_setup_pkg::OFS_CUR_LIMIT))  curLimit_nxt = wb_dat_i[4:0];
      // Impedance scale bytes staged
      if (hit(wb_adr_i, haptic_setup_pkg::OFS_IMP_HIGH)) begin
        impHigh_nxt    = wb_dat_i[7:0];
        impSeen_nxt[1] = 1'b1;
      end
      if (hit(wb_adr_i, haptic_setup_pkg::OFS_IMP_LOW)) begin
        impLow_nxt     = wb_dat_i[7:0];
        impSeen_nxt[0] = 1'b1;
      end
      // Period parts staged, low part 7 bits
      if (hit(wb_adr_i, haptic_setup_pkg::OFS_PER_HIGH)) begin
        perHigh_nxt    = wb_dat_i[7:0];
        perSeen_nxt[1] = 1'b1;
      end
      if (hit(wb_adr_i, haptic_setup_pkg::OFS_PER_LOW)) begin
        perLow_nxt     = wb_dat_i[6:0];
        perSeen_nxt[0] = 1'b1;
      end
      // Mode select, zero is inactive
      if (hit(wb_adr_i, haptic_setup_pkg::OFS_PLAY_MODE))  playMode_nxt = wb_dat_i[2:0];
      if (hit(wb_adr_i, haptic_setup_pkg::OFS_STORE_UNLOCK)) unlock_nxt = wb_dat_i[0];
      if (hit(wb_adr_i, haptic_setup_pkg::OFS_STORE_ADDR)) storeAddr_nxt = wb_dat_i[7:0];
      // Data writes step the pointer when accepted
      if (storeWe) storeAddr_nxt = storeAddr_r + 8'h01;
    end
    // Commit only once both bytes are
    if (impSeen_nxt == 2'b11) begin
      impedance_nxt = {impHigh_nxt, impLow_nxt};
      impSeen_nxt   = 2'b00;
    end
    // New period adopted once complete
    if (perSeen_nxt == 2'b11) begin
      period_nxt  = {perHigh_nxt, perLow_nxt};
      perSeen_nxt = 2'b00;
    end
  end

  // Settings registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      actCfg_r    <= 5'h00;
      nomLimit_r  <= haptic_setup_pkg::RST_BYTE;
      peakLimit_r <= haptic_setup_pkg::RST_BYTE;
      curLimit_r  <= 5'h00;
      impHigh_r   <= haptic_setup_pkg::RST_BYTE;
      impLow_r    <= haptic_setup_pkg::RST_BYTE;
      impSeen_r   <= 2'h0;
      impedance_r <= haptic_setup_pkg::RST_IMPEDANCE;
      perHigh_r   <= haptic_setup_pkg::RST_BYTE;
      perLow_r    <= 7'h00;
      perSeen_r   <= 2'h0;
      period_r    <= haptic_setup_pkg::RST_PERIOD;
      playMode_r  <= 3'h0;
      unlock_r    <= 1'b0;
      storeAddr_r <= haptic_setup_pkg::FIRST_SLOT_LOC;
    end else begin
      actCfg_r    <= actCfg_nxt;
      nomLimit_r  <= nomLimit_nxt;
      peakLimit_r <= peakLimit_nxt;
      curLimit_r  <= curLimit_nxt;
      impHigh_r   <= impHigh_nxt;
      impLow_r    <= impLow_nxt;
      impSeen_r   <= impSeen_nxt;
      impedance_r <= impedance_nxt;
      perHigh_r   <= perHigh_nxt;
      perLow_r    <= perLow_nxt;
      perSeen_r   <= perSeen_nxt;
      period_r    <= period_nxt;
      playMode_r  <= playMode_nxt;
      unlock_r    <= unlock_nxt;
      storeAddr_r <= storeAddr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pattern store
  // ----------------------------------------------------------------
  // Unlocked, booted and inactive only
  assign storeOpen = unlock_r && booted &&
                     (playMode_r == haptic_setup_pkg::MODE_INACTIVE);

  logic [7:0] store_r [haptic_setup_pkg::STORE_DEPTH];   // Pattern bytes
  assign storeWe = wrReq && storeOpen &&
                   hit(wb_adr_i, haptic_setup_pkg::OFS_STORE_DATA);

  // Store contents; cleared only by power-on reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < haptic_setup_pkg::STORE_DEPTH; i++)
        store_r[i] <= 8'h00;
    end else if (storeWe) begin
      store_r[storeAddr_r] <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Read mux and acknowledge
  // ----------------------------------------------------------------
  logic [31:0] rdData_nxt;   // Read word
  logic        ack_nxt;      // Acknowledge

  // Read data selection; unmapped reads zero
  always_comb begin
    rdData_nxt = 32'h0000_0000;
    ack_nxt    = req;
    unique case (wb_adr_i)
      haptic_setup_pkg::OFS_STATUS:       rdData_nxt = {26'h0, playMode_r, unlock_r,
                                                        playMode_r == 3'h0, booted};
      haptic_setup_pkg::OFS_ACT_CFG:      rdData_nxt = {27'h0, actCfg_r};
      haptic_setup_pkg::OFS_NOM_LIMIT:    rdData_nxt = {24'h0, nomLimit_r};
      haptic_setup_pkg::OFS_PEAK_LIMIT:   rdData_nxt = {24'h0, peakLimit_r};
      haptic_setup_pkg::OFS_CUR_LIMIT:    rdData_nxt = {27'h0, curLimit_r};
      haptic_setup_pkg::OFS_IMP_HIGH:     rdData_nxt = {24'h0, impedance_r[15:8]};
      haptic_setup_pkg::OFS_IMP_LOW:      rdData_nxt = {24'h0, impedance_r[7:0]};
      haptic_setup_pkg::OFS_PER_HIGH:     rdData_nxt = {24'h0, period_r[14:7]};
      haptic_setup_pkg::OFS_PER_LOW:      rdData_nxt = {25'h0, period_r[6:0]};
      haptic_setup_pkg::OFS_PLAY_MODE:    rdData_nxt = {29'h0, playMode_r};
      haptic_setup_pkg::OFS_STORE_UNLOCK: rdData_nxt = {31'h0, unlock_r};
      // First slot location readable
      haptic_setup_pkg::OFS_STORE_START:  rdData_nxt = {24'h0, haptic_setup_pkg::FIRST_SLOT_LOC};
      haptic_setup_pkg::OFS_STORE_ADDR:   rdData_nxt = {24'h0, storeAddr_r};
      haptic_setup_pkg::OFS_STORE_DATA:   rdData_nxt = {24'h0, store_r[storeAddr_r]};
      default:                            rdData_nxt = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Drive outputs
  // ----------------------------------------------------------------
  haptic_setup_pkg::drive_cfg_type cfg_nxt;   // Bundle to register
  logic wbOk;                                  // Wideband allowed

  // Wideband in three modes and 25..1000 Hz period
  assign wbOk = actCfg_r[haptic_setup_pkg::BIT_WIDEBAND] && !actCfg_r[haptic_setup_pkg::BIT_KIND]
                && (playMode_r == haptic_setup_pkg::MODE_DIRECT
                    || playMode_r == haptic_setup_pkg::MODE_REG_PLAY
                    || playMode_r == haptic_setup_pkg::MODE_EDGE_PLAY)
                && period_r >= haptic_setup_pkg::WB_PERIOD_MIN
                && period_r <= haptic_setup_pkg::WB_PERIOD_MAX;

  // Assemble settings bundle
  always_comb begin
    cfg_nxt.kindRotating     = actCfg_r[haptic_setup_pkg::BIT_KIND];
    cfg_nxt.followEn         = actCfg_r[haptic_setup_pkg::BIT_FOLLOW_EN];
    cfg_nxt.overdriveEn      = actCfg_r[haptic_setup_pkg::BIT_OVERDRV_EN];
    cfg_nxt.brakeEn          = actCfg_r[haptic_setup_pkg::BIT_BRAKE_EN];
    cfg_nxt.wideband         = wbOk;
    cfg_nxt.nominalLimit     = nomLimit_r;
    cfg_nxt.peakLimit        = peakLimit_r;
    cfg_nxt.currentLimitCode = curLimit_r;
    cfg_nxt.impedanceScale   = impedance_r;
    cfg_nxt.resonancePeriod  = period_r;
  end

  // Output registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      driveCfg        <= '0;
      bootDone        <= 1'b0;
      lowPower        <= 1'b0;
      assistActive    <= 1'b0;
      brakeReverse    <= 1'b0;
      sensingRateMode <= 1'b0;
      widebandActive  <= 1'b0;
      wb_dat_o        <= 32'h0000_0000;
      wb_ack_o        <= 1'b0;
    end else begin
      driveCfg        <= cfg_nxt;
      bootDone        <= booted;
      // Inactive after boot is lowest power
      lowPower        <= booted && (playMode_r == haptic_setup_pkg::MODE_INACTIVE);
      // Assist follows the overdrive enable
      assistActive    <= actCfg_r[haptic_setup_pkg::BIT_OVERDRV_EN];
      // Reverse drive follows the brake enable
      brakeReverse    <= actCfg_r[haptic_setup_pkg::BIT_BRAKE_EN];
      // Period means sensing rate on rotating mass
      sensingRateMode <= actCfg_r[haptic_setup_pkg::BIT_KIND];
      widebandActive  <= wbOk;
      wb_dat_o        <= rdData_nxt;
      wb_ack_o        <= ack_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence wrStoreLocked;
    wrReq && hit(wb_adr_i, haptic_setup_pkg::OFS_STORE_DATA) && !storeOpen;
  endsequence
  store_lock_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrStoreLocked |=> $stable(storeAddr_r))
    else $error("Store pointer moved while locked");
  store_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    storeWe |-> booted && playMode_r == 3'h0)
    else $error("Store written outside inactive");
  boot_time_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(booted) |-> bootCnt_r == 18'(haptic_setup_pkg::BOOT_CYCLES - 1))
    else $error("Boot ended early");
  period_pair_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $changed(period_r) |-> $past(perSeen_nxt) == 2'b11 || $past(perSeen_r) != 2'b00)
    else $error("Period changed without both parts");
  wide_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    widebandActive |-> $past(playMode_r) inside {3'h1, 3'h3, 3'h4})
    else $error("Wideband in wrong mode");
  wide_range_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    widebandActive |-> $past(period_r) >= 15'h02EE)
    else $error("Wideband period too short");
  enable_out_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrReq && hit(wb_adr_i, haptic_setup_pkg::OFS_ACT_CFG)
    |=> ##1 driveCfg.brakeEn == $past(wb_dat_i[3], 2))
    else $error("Brake enable not applied");
  low_power_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    booted && playMode_r == 3'h0 |=> lowPower)
    else $error("Inactive mode not low power");
  bus_ack_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("Ack missing");
endmodule

//--- drive_stage_model.sv
// Behavioural output stage on the far side of the setup block.
// Assumes it is clocked by core_clk and follows the drive bundle.
`timescale 1ns/10ps

module drive_stage_model (
  input  wire logic                           core_clk,
  input  wire haptic_setup_pkg::drive_cfg_type driveCfg,
  input  wire logic                           brakeReverse,
  input  wire logic                           assistActive,
  output logic                                reverseDrive,
  output logic                                phaseFlip
);
  // Stop by full reverse: phase flip when linear, inverted voltage when rotating
  always_ff @(posedge core_clk) begin
    reverseDrive <= brakeReverse;
    phaseFlip    <= brakeReverse & ~driveCfg.kindRotating;
  end
endmodule

//--- haptic_drive_setup_control_tb_top.sv
// Self-checking bench for the haptic setup register bank.
// Assumes a 100 MHz clock and a classic Wishbone single-cycle master.
`timescale 1ns/10ps

module haptic_drive_setup_control_tb_top;
  logic core_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, v;
  logic ack, bootDone, lowPower, assist, brake, sense, wide, rev, flip;
  haptic_setup_pkg::drive_cfg_type cfg;
  logic [31:0] expQ[$];                    // Expected read data, oldest first
  int failCount = 0, checksDone = 0, seed = 44, i;

  always #5 core_clk = ~core_clk;

  haptic_drive_setup_control u_haptic_drive_setup_control (.core_clk(core_clk), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .driveCfg(cfg), .bootDone(bootDone),
    .lowPower(lowPower), .assistActive(assist), .brakeReverse(brake),
    .sensingRateMode(sense), .widebandActive(wide));
  drive_stage_model u_drive_stage_model (.core_clk(core_clk), .driveCfg(cfg),
    .brakeReverse(brake), .assistActive(assist), .reverseDrive(rev), .phaseFlip(flip));

  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checksDone++;
    if (s !== e) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // One classic cycle, held until ack is sampled high
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge core_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    n = 0;
    do begin @(posedge core_clk); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) failCount++;
    cyc <= 0; stb <= 0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d); bus(1, a, d); endtask
  task automatic rd(logic [7:0] a, logic [31:0] e); expQ.push_back(e); bus(0, a, 0); endtask
  task automatic setp(logic [14:0] p); wr(8'h1C, p[14:7]); wr(8'h20, p[6:0]); endtask
  task automatic settle; repeat (2) @(posedge core_clk); endtask

  // Read data watcher: compares against the oldest note
  always @(posedge core_clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (expQ.size() == 0) chk("unexpected read", 32'h0000_0000, 32'hFFFF_FFFF);
      else chk("read data", expQ.pop_front(), rdat);
    end
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Watchdog beyond boot time plus traffic
  initial begin
    #2_000_000;
    failCount++;
    end_of_test;
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    chk("boot early", 0, bootDone);
    for (i = 0; i < 160000 && bootDone !== 1'b1; i++) @(posedge core_clk);
    chk("boot done", 1, bootDone);
    chk("boot length", haptic_setup_pkg::BOOT_CYCLES + 2, i);
    chk("low power", 1, lowPower);
    rd(8'h00, 32'h0000_0003);
    rd(8'h2C, 32'h0000_0000);
    repeat (8) begin
      v = $random(seed) & 32'h0000_000F;
      v[1] = v[1] | v[2] | v[3];
      wr(8'h04, v);
      settle;
      chk("assist", v[2], assist);
      chk("brake", v[3], brake);
      chk("follow", v[1], cfg.followEn);
      chk("kind", v[0], sense);
      chk("reverse", v[3], rev);
      chk("phase flip", v[3] & ~v[0], flip);
      rd(8'h04, v);
    end
    v = $random(seed);
    wr(8'h08, v); rd(8'h08, v & 32'h0000_00FF);
    wr(8'h0C, ~v); rd(8'h0C, ~v & 32'h0000_00FF);
    wr(8'h10, v); rd(8'h10, v & 32'h0000_001F);
    wr(8'h1C, 32'h0000_00A5);
    settle;
    chk("half period", 0, cfg.resonancePeriod);
    wr(8'h20, 32'h0000_0013);
    settle;
    chk("period", {8'hA5, 7'h13}, cfg.resonancePeriod);
    rd(8'h1C, 32'h0000_00A5); rd(8'h20, 32'h0000_0013);
    wr(8'h18, v[15:8]); wr(8'h14, v[23:16]);
    settle;
    chk("impedance", v[23:8], cfg.impedanceScale);
    wr(8'h04, 32'h0000_0010);
    setp(15'h02EE);
    for (i = 0; i < 5; i++) begin
      wr(8'h24, i);
      settle;
      chk("wideband mode", (i == 1 || i == 3 || i == 4), wide);
    end
    wr(8'h24, 1);
    setp(15'h02ED); settle; chk("wideband fast", 0, wide);
    setp(15'h7530); settle; chk("wideband slow", 1, wide);
    wr(8'h04, 32'h0000_0011); settle; chk("wideband rotating", 0, wide);
    wr(8'h04, 32'h0000_0010);
    setp(15'h7531); settle; chk("wideband beyond", 0, wide);
    wr(8'h28, 1); wr(8'h30, 0); wr(8'h34, 32'h0000_005A);
    wr(8'h24, 0); wr(8'h28, 0); wr(8'h30, 0); wr(8'h34, 32'h0000_00C3);
    wr(8'h30, 0); rd(8'h34, 32'h0000_0000);
    wr(8'h28, 1); wr(8'h34, 32'h0000_005A); wr(8'h34, 32'h0000_0077);
    wr(8'h30, 1); rd(8'h34, 32'h0000_0077);
    rd(8'h00, 32'h0000_0007);
    wr(8'h3C, 32'h0000_00FF); rd(8'h3C, 32'h0000_0000);
    repeat (3) @(posedge core_clk);
    chk("reads pending", 0, expQ.size());
    end_of_test;
  end
endmodule
